// >>> ucm_pkg.sv
package ucm_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_IRQ_SET = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_BAUD = 8'h20;
  localparam logic [7:0] OFS_GUARD = 8'h28;
  localparam logic [7:0] OFS_LOCK = 8'he4;

  // ------------------------------------------------------------
  // command bit positions
  // ------------------------------------------------------------
  localparam int CMD_LIN_WAKE = 21;
  localparam int CMD_LIN_ABORT = 20;
  localparam int CMD_HS_OFF = 19;
  localparam int CMD_HS_ON = 18;
  localparam int CMD_REARM_TO = 15;
  localparam int CMD_CLR_NONACK_FLAG = 14;
  localparam int CMD_SEND_ADDR = 12;
  localparam int CMD_START_TO = 11;
  localparam int CMD_STOP_BRK = 10;
  localparam int CMD_START_BRK = 9;
  localparam int CMD_CLR_ERR = 8;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_TX_ON = 6;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_RX_ON = 4;
  localparam int CMD_TX_RST = 3;
  localparam int CMD_RX_RST = 2;

  // ------------------------------------------------------------
  // mode_config fields
  // ------------------------------------------------------------
  localparam int MD_OVER = 19;
  localparam int MD_NINE = 17;
  localparam int MD_ORDER_POL = 16;
  localparam int MD_LOOP_HI = 15;
  localparam int MD_LOOP_LO = 14;
  localparam int MD_STOP_HI = 13;
  localparam int MD_STOP_LO = 12;
  localparam int MD_PAR_HI = 11;
  localparam int MD_PAR_LO = 9;
  localparam int MD_SYNC_PHA = 8;
  localparam int MD_CHAR_LEN_SEL_HI = 7;
  localparam int MD_CHAR_LEN_SEL_LO = 6;
  localparam int MD_MODE_HI = 3;
  localparam int MD_MODE_LO = 0;
  localparam logic [31:0] MODE_WR_MASK = 32'h001f_ffff;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  localparam logic [3:0] MODE_SPI_MASTER = 4'he;
  localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;
  localparam logic [1:0] PAR_MULTIDROP = 2'b11;

  localparam logic [1:0] LOOP_NORMAL = 2'b00;
  localparam logic [1:0] LOOP_ECHO = 2'b01;
  localparam logic [1:0] LOOP_LOCAL = 2'b10;
  localparam logic [1:0] LOOP_REMOTE = 2'b11;

  localparam logic [1:0] STOP_ONE_HALF = 2'b01;
  localparam logic [1:0] STOP_RESERVED = 2'b11;

  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [3:0] MIN_CHAR_BITS = 4'h5;

  // ------------------------------------------------------------
  // flag and mask layout
  // ------------------------------------------------------------
  localparam logic [31:0] IRQ_VALID = 32'h3e08_f7e7;
  localparam int FL_LIN_ERR_LO = 25;
  localparam int FL_NONACK_FLAG = 13;
  localparam int FL_TXEMPTY = 9;
  localparam int FL_TIMEOUT = 8;
  localparam int FL_PARE = 7;
  localparam int FL_FRAME = 6;
  localparam int FL_OVRE = 5;
  localparam int FL_RXBRK = 2;
  localparam int LOCK_BIT = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [7:0] GUARD_MIN_BITS = 8'd12;
  localparam logic [4:0] SAMPLES_X16 = 5'd16;
  localparam logic [4:0] SAMPLES_X8 = 5'd8;

  function automatic logic ucm_is_spi(input logic [3:0] mode);
    return (mode == MODE_SPI_MASTER) || (mode == MODE_SPI_SLAVE);
  endfunction : ucm_is_spi

  function automatic logic ucm_is_spi_master(input logic [3:0] mode);
    return mode == MODE_SPI_MASTER;
  endfunction : ucm_is_spi_master

endpackage : ucm_pkg

// >>> ucm_bit_tick.sv
module ucm_bit_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] baud_div,
  input wire logic sample_x8,
  output logic bit_tick
);
  import ucm_pkg::*;

  logic [20:0] count;
  logic [20:0] period;

  // a bit lasts baud_div times the oversampling factor; zero stops the tick
  assign period = 21'(baud_div) * 21'(sample_x8 ? SAMPLES_X8 : SAMPLES_X16);

  always_ff @(posedge clk) begin
    if (!rst_n || period == 21'h0) begin
      count <= 21'h0;
      bit_tick <= 1'b0;
    end else if (count >= period - 21'h1) begin
      count <= 21'h0;
      bit_tick <= 1'b1;
    end else begin
      count <= count + 21'h1;
      bit_tick <= 1'b0;
    end
  end

endmodule : ucm_bit_tick

// >>> ucm_break_seq.sv
module ucm_break_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire logic start_break,
  input wire logic stop_break,
  input wire logic tx_idle,
  input wire logic tx_reset,
  input wire logic [7:0] guard_time,
  output logic break_pending,
  output logic break_active,
  output logic guard_active
);
  import ucm_pkg::*;

  logic [7:0] guard_left;

  always_ff @(posedge clk) begin
    if (!rst_n || tx_reset) begin
      break_pending <= 1'b0;
      break_active <= 1'b0;
    end else if (break_active) begin
      if (stop_break) begin
        break_active <= 1'b0;
      end
    end else if (break_pending) begin
      if (tx_idle) begin
        break_pending <= 1'b0;
        break_active <= 1'b1;
      end
    end else if (start_break) begin
      break_pending <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || tx_reset) begin
      guard_left <= 8'h0;
      guard_active <= 1'b0;
    end else if (break_active && stop_break) begin
      guard_left <= (guard_time > GUARD_MIN_BITS) ? guard_time : GUARD_MIN_BITS;
      guard_active <= 1'b1;
    end else if (guard_active && bit_tick) begin
      guard_left <= guard_left - 8'h1;
      guard_active <= guard_left != 8'h1;
    end
  end

endmodule : ucm_break_seq

// >>> ucm_regs.sv
// Function
// - writing one to lin_wake_cmd sends a LIN wakeup; zero does nothing
// - writing one to lin_abort_cmd aborts the running LIN transmission
// - handshake off drives RTS high, or releases chip select in SPI master
// - handshake on without handshake off drives RTS low, or forces chip select low in SPI master
// - rearm_timeout_cmd reloads the time-out counter and clears its flag
// - clear_nonack_cmd clears the non-acknowledge flag
// - send_address_cmd in multidrop marks the next written character as address
// - start_timeout_cmd cancels countdown, clears flag, restarts after next character
// - stop_break_cmd ends break, then sends ones for max(guard, 12) bits
// - start_break_cmd begins break once transmitter empties; ignored during break
// - clear_errors_cmd clears parity, framing, overrun, break and LIN error flags
// - tx off disables transmitter; tx on enables only without tx off
// - rx off disables receiver; rx on enables only without rx off
// - tx and rx reset commands reset their side; zero bits do nothing
// - mode_config accepts writes only while write_lock_on is clear
// - oversampling bit selects 16x when zero, 8x when one
// - nine_bit_sel gives 9 bits, else char_len_sel gives 5 to 8
// - bit 16 is bit order outside SPI, clock idle level in SPI
// - bit 8 is clock phase in SPI, synchronous select otherwise
// - loop_mode_sel picks normal, echo, local loopback or remote loopback
// - stop_bits_sel picks 1, 1.5 async only, or 2; others reserved
// - a one in an IRQ_VALID bit of irq_enable_set sets the matching irq_mask bit
module ucm_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tx_idle,
  input wire logic tx_char_taken,
  input wire logic tx_serial,
  input wire logic rxd_pin,
  input wire logic timeout_evt,
  input wire logic nonack_flag_evt,
  input wire logic parity_err_evt,
  input wire logic frame_err_evt,
  input wire logic overrun_evt,
  input wire logic rx_break_evt,
  input wire logic [4:0] lin_err_evt,
  output logic txd_pin,
  output logic rx_serial,
  output logic rts_pin,
  output logic tx_enabled,
  output logic rx_enabled,
  output logic tx_reset_pulse,
  output logic rx_reset_pulse,
  output logic lin_wake_pulse,
  output logic lin_abort_pulse,
  output logic rearm_timeout_pulse,
  output logic start_timeout_pulse,
  output logic tx_addr_mark,
  output logic break_active,
  output logic guard_active,
  output logic bit_tick,
  output logic [3:0] char_bits,
  output logic sample_x8,
  output logic msb_first,
  output logic clk_idle_high,
  output logic sync_mode,
  output logic spi_change_leading,
  output logic [1:0] loop_mode,
  output logic [1:0] stop_bits,
  output logic stop_cfg_bad,
  output logic [31:0] irq_mask
);
  import ucm_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic [31:0] mode_config;
  logic [15:0] baud_div;
  logic [7:0] tx_guard_time;
  logic write_lock_on;
  logic [31:0] channel_flags;
  logic wr_fire;
  logic [31:0] cmd;
  logic [31:0] next_readdata;
  logic break_pending;
  logic brk_act;
  logic grd_act;
  logic tick;

  // one wait state: the answer is stable for the whole accepting cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign wr_fire = avs_write && !avs_waitrequest;
  // zero bits of a command write never act
  assign cmd = (wr_fire && avs_address == OFS_CMD) ? avs_writedata : 32'h0;

  always_comb begin
    unique case (avs_address)
      OFS_MODE: next_readdata = mode_config;
      OFS_IRQ_MASK: next_readdata = irq_mask;
      OFS_FLAGS: next_readdata = channel_flags;
      OFS_BAUD: next_readdata = {16'h0, baud_div};
      OFS_GUARD: next_readdata = {24'h0, tx_guard_time};
      OFS_LOCK: next_readdata = {31'h0, write_lock_on};
      default: next_readdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_lock_on <= 1'b0;
    end else if (wr_fire && avs_address == OFS_LOCK) begin
      write_lock_on <= avs_writedata[LOCK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_config <= MODE_RESET;
    end else if (wr_fire && avs_address == OFS_MODE && !write_lock_on) begin
      mode_config <= avs_writedata & MODE_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      baud_div <= 16'h0;
      tx_guard_time <= 8'h0;
    end else if (wr_fire && !write_lock_on) begin
      if (avs_address == OFS_BAUD) begin
        baud_div <= avs_writedata[15:0];
      end
      if (avs_address == OFS_GUARD) begin
        tx_guard_time <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask <= 32'h0;
    end else if (wr_fire && avs_address == OFS_IRQ_SET) begin
      irq_mask <= irq_mask | (avs_writedata & IRQ_VALID);
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      char_bits <= MIN_CHAR_BITS;
      sample_x8 <= 1'b0;
      msb_first <= 1'b0;
      clk_idle_high <= 1'b0;
      sync_mode <= 1'b0;
      spi_change_leading <= 1'b0;
      loop_mode <= LOOP_NORMAL;
      stop_bits <= 2'b00;
      stop_cfg_bad <= 1'b0;
    end else begin
      char_bits <= mode_config[MD_NINE] ? NINE_BITS :
                   MIN_CHAR_BITS + {2'b00, mode_config[MD_CHAR_LEN_SEL_HI:MD_CHAR_LEN_SEL_LO]};
      sample_x8 <= mode_config[MD_OVER];
      msb_first <= !ucm_is_spi(mode_config[MD_MODE_HI:MD_MODE_LO]) &&
                   mode_config[MD_ORDER_POL];
      clk_idle_high <= ucm_is_spi(mode_config[MD_MODE_HI:MD_MODE_LO]) &&
                       mode_config[MD_ORDER_POL];
      sync_mode <= !ucm_is_spi(mode_config[MD_MODE_HI:MD_MODE_LO]) &&
                   mode_config[MD_SYNC_PHA];
      spi_change_leading <= ucm_is_spi(mode_config[MD_MODE_HI:MD_MODE_LO]) &&
                            !mode_config[MD_SYNC_PHA];
      loop_mode <= mode_config[MD_LOOP_HI:MD_LOOP_LO];
      stop_bits <= mode_config[MD_STOP_HI:MD_STOP_LO];
      stop_cfg_bad <= (mode_config[MD_STOP_HI:MD_STOP_LO] == STOP_RESERVED) ||
                      (mode_config[MD_STOP_HI:MD_STOP_LO] == STOP_ONE_HALF &&
                       mode_config[MD_SYNC_PHA] &&
                       !ucm_is_spi(mode_config[MD_MODE_HI:MD_MODE_LO]));
    end
  end

  // ------------------------------------------------------------
  // one-shot commands
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lin_wake_pulse <= 1'b0;
      lin_abort_pulse <= 1'b0;
      rearm_timeout_pulse <= 1'b0;
      start_timeout_pulse <= 1'b0;
      tx_reset_pulse <= 1'b0;
      rx_reset_pulse <= 1'b0;
    end else begin
      lin_wake_pulse <= cmd[CMD_LIN_WAKE];
      lin_abort_pulse <= cmd[CMD_LIN_ABORT];
      rearm_timeout_pulse <= cmd[CMD_REARM_TO];
      start_timeout_pulse <= cmd[CMD_START_TO];
      tx_reset_pulse <= cmd[CMD_TX_RST];
      rx_reset_pulse <= cmd[CMD_RX_RST];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_enabled <= 1'b0;
    end else if (cmd[CMD_TX_OFF]) begin
      tx_enabled <= 1'b0;
    end else if (cmd[CMD_TX_ON]) begin
      tx_enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_enabled <= 1'b0;
    end else if (cmd[CMD_RX_OFF]) begin
      rx_enabled <= 1'b0;
    end else if (cmd[CMD_RX_ON]) begin
      rx_enabled <= 1'b1;
    end
  end

  // rts idles high, which is also a released chip select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rts_pin <= 1'b1;
    end else if (cmd[CMD_HS_OFF]) begin
      rts_pin <= 1'b1;
    end else if (cmd[CMD_HS_ON]) begin
      rts_pin <= 1'b0;
    end
  end

  // a new mark request wins over a character taken in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n || tx_reset_pulse) begin
      tx_addr_mark <= 1'b0;
    end else if (cmd[CMD_SEND_ADDR] &&
                 mode_config[MD_PAR_HI:MD_PAR_HI-1] == PAR_MULTIDROP) begin
      tx_addr_mark <= 1'b1;
    end else if (tx_char_taken) begin
      tx_addr_mark <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status flags (hardware set wins over a clearing command)
  // ------------------------------------------------------------
  logic timeout_flag;
  logic nonack_flag;
  logic [3:0] rx_err;
  logic [4:0] lin_err;
  logic [3:0] rx_err_evt;

  assign rx_err_evt = {parity_err_evt, frame_err_evt, overrun_evt, rx_break_evt};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout_flag <= 1'b0;
    end else if (timeout_evt) begin
      timeout_flag <= 1'b1;
    end else if (cmd[CMD_REARM_TO] || cmd[CMD_START_TO]) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nonack_flag <= 1'b0;
    end else if (nonack_flag_evt) begin
      nonack_flag <= 1'b1;
    end else if (cmd[CMD_CLR_NONACK_FLAG]) begin
      nonack_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_err <= 4'h0;
      lin_err <= 5'h0;
    end else begin
      rx_err <= rx_err_evt | (cmd[CMD_CLR_ERR] ? 4'h0 : rx_err);
      lin_err <= lin_err_evt | (cmd[CMD_CLR_ERR] ? 5'h0 : lin_err);
    end
  end

  always_comb begin
    channel_flags = 32'h0;
    channel_flags[FL_LIN_ERR_LO +: 5] = lin_err;
    channel_flags[FL_NONACK_FLAG] = nonack_flag;
    channel_flags[FL_TXEMPTY] = tx_enabled && tx_idle;
    channel_flags[FL_TIMEOUT] = timeout_flag;
    channel_flags[FL_PARE] = rx_err[3];
    channel_flags[FL_FRAME] = rx_err[2];
    channel_flags[FL_OVRE] = rx_err[1];
    channel_flags[FL_RXBRK] = rx_err[0];
  end

  // ------------------------------------------------------------
  // bit timing and break sequencing
  // ------------------------------------------------------------
  ucm_bit_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .baud_div(baud_div),
    .sample_x8(mode_config[MD_OVER]),
    .bit_tick(tick)
  );

  ucm_break_seq u_brk (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(tick),
    .start_break(cmd[CMD_START_BRK]),
    .stop_break(cmd[CMD_STOP_BRK]),
    .tx_idle(tx_idle),
    .tx_reset(tx_reset_pulse),
    .guard_time(tx_guard_time),
    .break_pending(break_pending),
    .break_active(brk_act),
    .guard_active(grd_act)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_tick <= 1'b0;
      break_active <= 1'b0;
      guard_active <= 1'b0;
    end else begin
      bit_tick <= tick;
      break_active <= brk_act;
      guard_active <= grd_act;
    end
  end

  // ------------------------------------------------------------
  // pin routing
  // ------------------------------------------------------------
  logic rxd_meta;
  logic rxd_sync;
  logic tx_line;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_pin;
      rxd_sync <= rxd_meta;
    end
  end

  // break holds the line low; guard and a disabled transmitter hold it idle high
  assign tx_line = brk_act ? 1'b0 :
                   (grd_act || !tx_enabled) ? 1'b1 : tx_serial;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txd_pin <= 1'b1;
      rx_serial <= 1'b1;
    end else begin
      unique case (mode_config[MD_LOOP_HI:MD_LOOP_LO])
        LOOP_NORMAL: begin
          txd_pin <= tx_line;
          rx_serial <= rxd_sync;
        end
        LOOP_ECHO: begin
          txd_pin <= rxd_sync;
          rx_serial <= rxd_sync;
        end
        LOOP_LOCAL: begin
          txd_pin <= 1'b1;
          rx_serial <= tx_line;
        end
        LOOP_REMOTE: begin
          txd_pin <= rxd_sync;
          rx_serial <= 1'b1;
        end
      endcase
    end
  end

endmodule : ucm_regs

// >>> ucm_props.sv
module ucm_props
  import ucm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic rts_pin,
  input wire logic tx_enabled,
  input wire logic rx_enabled,
  input wire logic lin_wake_pulse,
  input wire logic lin_abort_pulse,
  input wire logic tx_reset_pulse,
  input wire logic [31:0] irq_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmd, irq_wr, wk;
  logic [31:0] d;
  assign d = avs_writedata;
  assign cmd = avs_write && !avs_waitrequest && (avs_address == OFS_CMD);
  assign irq_wr = avs_write && !avs_waitrequest && (avs_address == OFS_IRQ_SET);
  assign wk = cmd && d[CMD_LIN_WAKE];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // bus handshake
  // ----
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_ONE_WAIT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // ----
  // commands
  // ----
  AST_TX_OFF: assert property (cmd && d[CMD_TX_OFF] |-> ##2 !tx_enabled)
    else $error("transmitter still enabled after off");
  AST_TX_ON: assert property (cmd && d[CMD_TX_ON] && !d[CMD_TX_OFF] |-> ##2 tx_enabled)
    else $error("transmitter not enabled");
  AST_RX_OFF: assert property (cmd && d[CMD_RX_OFF] |-> ##2 !rx_enabled)
    else $error("receiver still enabled after off");
  AST_RTS_OFF: assert property (cmd && d[CMD_HS_OFF] |-> ##2 rts_pin)
    else $error("rts not high after handshake off");
  AST_RTS_ON: assert property (cmd && d[CMD_HS_ON] && !d[CMD_HS_OFF] |-> ##2 !rts_pin)
    else $error("rts not low after handshake on");
  AST_WAKE: assert property (wk |-> ##[1:2] lin_wake_pulse)
    else $error("no wakeup pulse");
  AST_WAKE_CAUSE: assert property ($rose(lin_wake_pulse) |-> $past(wk) || $past(wk, 2))
    else $error("wakeup pulse without command");
  AST_ABORT: assert property (cmd && d[CMD_LIN_ABORT] |-> ##[1:2] lin_abort_pulse)
    else $error("no abort pulse");
  AST_TX_RST: assert property (cmd && d[CMD_TX_RST] |-> ##[1:2] tx_reset_pulse)
    else $error("no transmitter reset pulse");
  // ----
  // interrupt mask
  // ----
  AST_IRQ_SET: assert property (irq_wr |-> ##2 ((irq_mask & $past(d, 2) & IRQ_VALID) ==
    ($past(d, 2) & IRQ_VALID)))
    else $error("mask bits not set");
  AST_IRQ_KEEP: assert property ($past(rst_n) |-> ((~irq_mask & $past(irq_mask)) == 32'h0))
    else $error("mask bit cleared");
endmodule : ucm_props

bind ucm_regs ucm_props u_props (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .rts_pin, .tx_enabled, .rx_enabled, .lin_wake_pulse,
  .lin_abort_pulse, .tx_reset_pulse, .irq_mask);

// >>> ucm_node.sv
module ucm_node (
  input wire logic clk,
  input wire logic drive_lvl,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_pin = 1'b1;
  // the remote line only moves on the node's own clock, never mid-cycle
  always @(posedge clk) begin
    rxd_pin <= drive_lvl;
  end
endmodule : ucm_node

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, irq_mask;
  logic tx_idle = 1'b1, tx_char_taken = 1'b0, tx_serial = 1'b1, drv = 1'b1, ev = 1'b0;
  logic avs_waitrequest, txd_pin, rx_serial, rts_pin, tx_enabled, rx_enabled, rxd_pin;
  logic tx_reset_pulse, rx_reset_pulse, lin_wake_pulse, lin_abort_pulse, rearm_timeout_pulse;
  logic start_timeout_pulse, tx_addr_mark, break_active, guard_active, bit_tick, sample_x8;
  logic msb_first, clk_idle_high, sync_mode, spi_change_leading, stop_cfg_bad;
  logic [3:0] char_bits;
  logic [1:0] loop_mode, stop_bits;
  logic [5:0] pv;
  int n_mismatch = 0, cmp_count = 0, k, n;
  int pb[6] = '{CMD_LIN_WAKE, CMD_LIN_ABORT, CMD_REARM_TO, CMD_START_TO, CMD_TX_RST, CMD_RX_RST};
  logic [31:0] er_d[9] = '{32'h0004_0040, 32'h0000_00c0, 32'h0008_0010, 32'h000c_0030,
    32'h0004_0050, 32'h0, 32'h0008_0080, 32'h0000_0020, 32'h0000_0050};
  logic [2:0] er_e[9] = '{3'h4, 3'h0, 3'h3, 3'h1, 3'h6, 3'h6, 3'h3, 3'h1, 3'h7};
  logic [31:0] md_d[9] = '{32'h0030_0000, 32'h0009_0040, 32'h0002_00c0, 32'h0000_4180,
    32'h0000_9100, 32'h0000_d000, 32'h0000_3000, 32'h0001_000e, 32'h0000_010f};
  logic [11:0] md_e[9] = '{12'h500, 12'h6c0, 12'h900, 12'h712, 12'h515, 12'h506, 12'h501,
    12'h528, 12'h500};
  assign pv = {lin_wake_pulse, lin_abort_pulse, rearm_timeout_pulse, start_timeout_pulse,
    tx_reset_pulse, rx_reset_pulse};

  ucm_regs DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tx_idle, .tx_char_taken, .tx_serial, .rxd_pin,
    .timeout_evt(ev), .nonack_flag_evt(ev), .parity_err_evt(ev), .frame_err_evt(ev),
    .overrun_evt(ev), .rx_break_evt(ev), .lin_err_evt({5{ev}}), .txd_pin, .rx_serial,
    .rts_pin, .tx_enabled, .rx_enabled, .tx_reset_pulse, .rx_reset_pulse, .lin_wake_pulse,
    .lin_abort_pulse, .rearm_timeout_pulse, .start_timeout_pulse, .tx_addr_mark,
    .break_active, .guard_active, .bit_tick, .char_bits, .sample_x8, .msb_first,
    .clk_idle_high, .sync_mode, .spi_change_leading, .loop_mode, .stop_bits, .stop_cfg_bad,
    .irq_mask);
  ucm_node u_node (.clk, .drive_lvl(drv), .rxd_pin);

  always #2 clk = ~clk;

  // ----
  // helpers
  // ----
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_mismatch++;
      finish_test();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp, "read");
  endtask : rd

  task automatic pulse(input logic [31:0] wd, input logic [5:0] exp);
    logic [5:0] seen;
    int c;
    seen = 6'h0;
    c = 0;
    wr(OFS_CMD, wd);
    repeat (4) begin
      #1;
      seen |= pv;
      c += $countones(pv);
      @(posedge clk);
    end
    check({seen, 8'(c)}, {exp, 8'($countones(exp))}, "pulses");
  endtask : pulse

  task automatic evp();
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask : evp

  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_MODE, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(8'h3c, 32'h0);
    check({txd_pin, rts_pin, char_bits}, 6'h35, "reset");
    for (k = 0; k < 6; k++) pulse(32'h1 << pb[k], 6'h20 >> k);
    pulse(32'h0, 6'h0);
    for (k = 0; k < 9; k++) begin
      wr(OFS_CMD, er_d[k]);
      tick(3);
      check({tx_enabled, rx_enabled, rts_pin}, er_e[k], "enables");
    end
    for (k = 0; k < 9; k++) begin
      wr(OFS_MODE, md_d[k]);
      rd(OFS_MODE, md_d[k] & MODE_WR_MASK);
      tick(2);
      check({char_bits, sample_x8, msb_first, clk_idle_high, sync_mode, spi_change_leading,
        loop_mode, stop_cfg_bad} & ((md_d[k][3:1] == 3'h7) ? 12'hfaf : 12'hfd7),
        md_e[k], "decode");
    end
    // chip select in spi master mode
    wr(OFS_MODE, 32'h0000_000e);
    wr(OFS_CMD, 32'h0004_0000);
    tick(3);
    check(rts_pin, 1'b0, "select forced");
    wr(OFS_CMD, 32'h0008_0000);
    tick(3);
    check(rts_pin, 1'b1, "select released");
    wr(OFS_LOCK, 32'h1);
    wr(OFS_MODE, 32'h0000_00c0);
    rd(OFS_MODE, 32'h0000_000e);
    wr(OFS_LOCK, 32'h0);
    wr(OFS_MODE, 32'h0000_0c00);
    wr(OFS_CMD, 32'h0000_1000);
    tick(3);
    check(tx_addr_mark, 1'b1, "addr mark");
    @(posedge clk) tx_char_taken <= 1'b1;
    @(posedge clk) tx_char_taken <= 1'b0;
    tick(3);
    check(tx_addr_mark, 1'b0, "addr used");
    evp();
    rd(OFS_FLAGS, 32'h3e00_23e4);
    wr(OFS_CMD, 32'h0000_0100);
    rd(OFS_FLAGS, 32'h0000_2300);
    wr(OFS_CMD, 32'h0000_4000);
    rd(OFS_FLAGS, 32'h0000_0300);
    wr(OFS_CMD, 32'h0000_8000);
    rd(OFS_FLAGS, 32'h0000_0200);
    evp();
    wr(OFS_CMD, 32'h0000_0800);
    rd(OFS_FLAGS, 32'h3e00_22e4);
    wr(OFS_BAUD, 32'h1);
    wr(OFS_GUARD, 32'h3);
    wr(OFS_CMD, 32'h0000_0400);
    tick(3);
    check(guard_active, 1'b0, "no guard");
    @(posedge clk) tx_idle <= 1'b0;
    wr(OFS_CMD, 32'h0000_0200);
    tick(4);
    check(break_active, 1'b0, "break waits");
    @(posedge clk) tx_idle <= 1'b1;
    tick(3);
    check(break_active, 1'b1, "break on");
    wr(OFS_CMD, 32'h0000_0400);
    n = 0;
    for (k = 0; k < 600; k++) begin
      @(posedge clk);
      #1;
      n += guard_active;
    end
    // twelve bit periods of sixteen clocks, one period of slack
    check({break_active, n >= 176 && n <= 208}, 2'b01, "guard");
    @(posedge clk) drv <= 1'b0;
    tick(5);
    check({rx_serial, txd_pin, stop_bits}, 4'h4, "route");
    wr(OFS_IRQ_SET, 32'h0000_0100);
    rd(OFS_IRQ_MASK, 32'h0000_0100);
    wr(OFS_IRQ_SET, 32'hffff_ffff);
    wr(OFS_IRQ_SET, 32'h0);
    rd(OFS_IRQ_MASK, IRQ_VALID);
    finish_test();
  end
endmodule : tb
